// >>> design/reset_wakeup_pkg.sv
// Constants shared by the reset sequencer, its glitch filter and its watchdog.
// Assumes a single 50 MHz clock domain.
package reset_wakeup_pkg;
  localparam int CLK_MHZ = 50;
  localparam int FILTER_NS = 100;
  localparam int FILTER_CYCLES = (FILTER_NS * CLK_MHZ) / 1000;
  localparam int WAKE_CYCLES = 4096;
  localparam int WDT_PRESCALE = 4;
  localparam logic [31:0] WDT_MIN_TIMEOUT = 32'h00000100;
  localparam logic [31:0] RESET_VECTOR = 32'h00000000;
  localparam logic [7:0] FEED_KEY1 = 8'haa;
  localparam logic [7:0] FEED_KEY2 = 8'h55;
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_TIMEOUT = 4'h1;
  localparam logic [3:0] ADDR_FEED = 4'h2;
  localparam logic [3:0] ADDR_COUNT = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h5;
  localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h6;
  localparam int MODE_ENABLE_BIT = 0;
  localparam int MODE_RESET_BIT = 1;
  localparam int STATUS_TIMEOUT_BIT = 0;
  localparam int STATUS_FEEDERR_BIT = 1;
  localparam int STATUS_WDRESET_BIT = 2;
  localparam logic [31:0] TIMEOUT_RESET = 32'h000000ff;
endpackage : reset_wakeup_pkg

// >>> design/glitch_filter.sv
// Glitch filter for the external reset pin.
// Assumes the pin is already synchronous to clk.
`timescale 1ns/1ns
module glitch_filter #(
  parameter int CYCLES = reset_wakeup_pkg::FILTER_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pinIn,
  output logic pinOut
);
  import reset_wakeup_pkg::*;
  typedef struct packed {
    logic [15:0] count;
    logic level;
  } state_type;
  state_type state_reg, state_next;
  always_comb begin
    state_next = state_reg;
    if (pinIn == state_reg.level) begin
      state_next.count = '0;
    end else if (state_reg.count >= 16'(CYCLES - 1)) begin
      state_next.level = pinIn;
      state_next.count = '0;
    end else begin
      state_next.count = state_reg.count + 16'h0001;
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= '{count: 16'h0000, level: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end
  assign pinOut = state_reg.level;
endmodule : glitch_filter

// >>> design/watchdog_timer.sv
// Watchdog: divide-by-4 prescaler and 32-bit down counter with feed check.
// Assumes feed and key strobes come from the register port of the parent.
`timescale 1ns/1ns
module watchdog_timer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic enabled,
  input wire logic [31:0] timeout,
  input wire logic feedStrobe,
  input wire logic [7:0] feedData,
  input wire logic otherWrite,
  output logic timeoutPulse,
  output logic feedError,
  output logic [31:0] count
);
  import reset_wakeup_pkg::*;
  typedef struct packed {
    logic [1:0] pre;
    logic [31:0] count;
    logic keyArmed;
  } state_type;
  state_type state_reg, state_next;
  logic goodFeed;
  always_comb begin
    state_next = state_reg;
    timeoutPulse = 1'b0;
    feedError = 1'b0;
    goodFeed = 1'b0;
    if (feedStrobe) begin
      if (!state_reg.keyArmed && feedData == FEED_KEY1) begin
        state_next.keyArmed = 1'b1;
      end else if (state_reg.keyArmed && feedData == FEED_KEY2) begin
        state_next.keyArmed = 1'b0;
        goodFeed = 1'b1;
      end else begin
        state_next.keyArmed = 1'b0;
        feedError = enabled;
      end
    end else if (otherWrite && state_reg.keyArmed) begin
      state_next.keyArmed = 1'b0;
      feedError = enabled;
    end
    if (goodFeed) begin
      state_next.count = timeout;
      state_next.pre = '0;
    end else if (enabled) begin
      state_next.pre = state_reg.pre + 2'(1);
      if (state_reg.pre == 2'(WDT_PRESCALE - 1)) begin
        if (state_reg.count == '0) begin
          timeoutPulse = 1'b1;
          state_next.count = timeout;
        end else begin
          state_next.count = state_reg.count - 32'h00000001;
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= '{pre: 2'h0, count: TIMEOUT_RESET, keyArmed: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end
  assign count = state_reg.count;
endmodule : watchdog_timer

// >>> design/reset_wakeup_watchdog.sv
// Chip reset sequencer with wake-up timer and watchdog.
// Assumes all inputs synchronous to clk; resetn is the power-on reset.
`timescale 1ns/1ns
module reset_wakeup_watchdog #(
  parameter int WAKE_COUNT = reset_wakeup_pkg::WAKE_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic extResetn,
  input wire logic oscRunning,
  input wire logic oscTick,
  input wire logic flashInitDone,
  input wire logic powerDownExit,
  input wire logic [3:0] addr,
  input wire logic [31:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [31:0] readData,
  output logic chipResetn,
  output logic coreRun,
  output logic [31:0] fetchAddress,
  output logic irq
);
  import reset_wakeup_pkg::*;

  typedef enum logic [1:0] {HOLD, WAKE, RUN} phase_type;
  typedef struct packed {
    phase_type phase;
    logic [15:0] wakeCount;
    logic wdEnable;
    logic wdResetMode;
    logic [31:0] timeout;
    logic [2:0] status;
    logic [2:0] irqEnable;
    logic [31:0] readData;
    logic [31:0] fetch;
  } state_type;
  state_type state_reg, state_next;

  logic pinFiltered;
  logic wdTimeout;
  logic wdFeedError;
  logic [31:0] wdCount;
  logic wdEvent;
  logic wdChipReset;
  logic chipResetActive;
  logic feedWrite;
  logic otherWrite;

  glitch_filter #(.CYCLES(FILTER_CYCLES)) filterPin (
    .clk(clk),
    .resetn(resetn),
    .pinIn(extResetn),
    .pinOut(pinFiltered)
  );

  assign feedWrite = writeStrobe && addr == ADDR_FEED;
  assign otherWrite = writeStrobe && addr != ADDR_FEED;

  watchdog_timer wdt (
    .clk(clk),
    .resetn(resetn && chipResetn),
    .enabled(state_reg.wdEnable),
    .timeout(state_reg.timeout),
    .feedStrobe(feedWrite),
    .feedData(writeData[7:0]),
    .otherWrite(otherWrite),
    .timeoutPulse(wdTimeout),
    .feedError(wdFeedError),
    .count(wdCount)
  );

  assign wdEvent = wdTimeout || wdFeedError;
  assign wdChipReset = wdEvent && state_reg.wdResetMode;
  assign chipResetActive = !pinFiltered || wdChipReset;

  always_comb begin
    state_next = state_reg;
    state_next.readData = '0;
    unique case (state_reg.phase)
      HOLD: begin
        state_next.wakeCount = '0;
        if (pinFiltered) begin
          state_next.phase = WAKE;
        end
      end
      WAKE: begin
        if (oscRunning && oscTick && state_reg.wakeCount < 16'(WAKE_COUNT)) begin
          state_next.wakeCount = state_reg.wakeCount + 16'h0001;
        end
        if (pinFiltered && oscRunning && flashInitDone
            && state_reg.wakeCount >= 16'(WAKE_COUNT)) begin
          state_next.phase = RUN;
          state_next.fetch = RESET_VECTOR;
        end
      end
      RUN: begin
        if (powerDownExit) begin
          state_next.phase = WAKE;
          state_next.wakeCount = '0;
        end
      end
    endcase
    if (state_reg.phase == RUN) begin
      if (writeStrobe) begin
        unique case (addr)
          ADDR_MODE: begin
            if (writeData[MODE_ENABLE_BIT]) begin
              state_next.wdEnable = 1'b1;
            end
            state_next.wdResetMode = writeData[MODE_RESET_BIT];
          end
          ADDR_TIMEOUT: begin
            state_next.timeout = (writeData < WDT_MIN_TIMEOUT) ?
              (WDT_MIN_TIMEOUT - 32'h00000001) : (writeData - 32'h00000001);
          end
          ADDR_IRQ_ENABLE: state_next.irqEnable = writeData[2:0];
          ADDR_IRQ_CLEAR: state_next.status = state_reg.status & ~writeData[2:0];
          default: ;
        endcase
      end
      if (readStrobe) begin
        unique case (addr)
          ADDR_MODE: state_next.readData = {30'h0, state_reg.wdResetMode, state_reg.wdEnable};
          ADDR_TIMEOUT: state_next.readData = state_reg.timeout + 32'h00000001;
          ADDR_COUNT: state_next.readData = wdCount;
          ADDR_STATUS: state_next.readData = {29'h0, state_reg.status};
          ADDR_IRQ_ENABLE: state_next.readData = {29'h0, state_reg.irqEnable};
          default: state_next.readData = '0;
        endcase
      end
      if (wdTimeout) begin
        state_next.status[STATUS_TIMEOUT_BIT] = 1'b1;
      end
      if (wdFeedError) begin
        state_next.status[STATUS_FEEDERR_BIT] = 1'b1;
      end
      if (wdEvent) begin
        state_next.wdEnable = 1'b0;
      end
    end
    if (chipResetActive) begin
      state_next.phase = HOLD;
      state_next.wakeCount = '0;
      state_next.wdEnable = 1'b0;
      state_next.wdResetMode = 1'b0;
      state_next.timeout = TIMEOUT_RESET;
      state_next.irqEnable = '0;
      state_next.readData = '0;
      state_next.fetch = RESET_VECTOR;
      state_next.status = '0;
      state_next.status[STATUS_WDRESET_BIT] = wdChipReset;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= '{phase: HOLD, wakeCount: 16'h0000, wdEnable: 1'b0,
                     wdResetMode: 1'b0, timeout: TIMEOUT_RESET, status: 3'h0,
                     irqEnable: 3'h0, readData: 32'h00000000, fetch: RESET_VECTOR};
    end else begin
      state_reg <= state_next;
    end
  end

  assign readData = state_reg.readData;
  assign chipResetn = state_reg.phase == RUN;
  assign coreRun = state_reg.phase == RUN;
  assign fetchAddress = state_reg.fetch;
  assign irq = |(state_reg.status & state_reg.irqEnable);
endmodule : reset_wakeup_watchdog

// >>> tb/reset_wakeup_watchdog_sva.sv
// Port checker for the reset sequencer, bound onto its top module.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ns
module reset_wakeup_watchdog_sva
  import reset_wakeup_pkg::*;
#(
  parameter int WAKE_COUNT = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic extResetn,
  input wire logic oscRunning,
  input wire logic oscTick,
  input wire logic flashInitDone,
  input wire logic powerDownExit,
  input wire logic readStrobe,
  input wire logic [31:0] readData,
  input wire logic chipResetn,
  input wire logic coreRun,
  input wire logic [31:0] fetchAddress,
  input wire logic irq
);
  logic [15:0] ticks_reg;
  // Oscillator ticks since the wake-up delay last had to restart
  always_ff @(posedge clk) begin
    if (!resetn || chipResetn || powerDownExit || !extResetn) begin
      ticks_reg <= 16'h0000;
    end else if (oscTick && oscRunning) begin
      ticks_reg <= ticks_reg + 16'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_core_tracks: assert property (coreRun == chipResetn)
    else $error("run flag off");
  chk_osc_at_release: assert property ($rose(coreRun) |-> $past(oscRunning))
    else $error("run without oscillator");
  chk_fetch_vector: assert property (chipResetn |-> fetchAddress == RESET_VECTOR)
    else $error("bad fetch address");
  chk_pin_resets: assert property (!extResetn [*8] |-> ##[0:4] !chipResetn)
    else $error("pin reset missed");
  chk_glitch_held: assert property (
      (chipResetn && extResetn) ##1 !extResetn [*2] ##1 extResetn [*6] |-> chipResetn)
    else $error("glitch reset chip");
  chk_wake_count: assert property ($rose(chipResetn) |-> 32'(ticks_reg) >= WAKE_COUNT)
    else $error("wake delay short");
  chk_ready_gate: assert property ($rose(chipResetn) |-> $past(flashInitDone) && $past(extResetn))
    else $error("released too early");
  chk_wake_after_pd: assert property (powerDownExit |-> ##2 !coreRun [*8])
    else $error("no wake delay");
  chk_irq_cleared: assert property (!chipResetn ##1 !chipResetn |-> !irq)
    else $error("irq in reset");
  chk_read_quiet: assert property (!$past(readStrobe) |-> readData == 32'h00000000)
    else $error("stray read data");
  cover property ($rose(chipResetn));
  cover property (powerDownExit ##1 !coreRun [*2]);
  cover property ($rose(irq));
endmodule : reset_wakeup_watchdog_sva
bind reset_wakeup_watchdog reset_wakeup_watchdog_sva #(.WAKE_COUNT(WAKE_COUNT)) chk (
  .clk(clk), .resetn(resetn), .extResetn(extResetn), .oscRunning(oscRunning),
  .oscTick(oscTick), .flashInitDone(flashInitDone), .powerDownExit(powerDownExit),
  .readStrobe(readStrobe), .readData(readData), .chipResetn(chipResetn),
  .coreRun(coreRun), .fetchAddress(fetchAddress), .irq(irq));

// >>> tb/reset_source_model.sv
// Far-side model: reset pin driver, crystal oscillator and flash controller.
// Assumes bench requests change just after rising clock edges.
`timescale 1ns/1ns
module reset_source_model (
  input wire logic clk,
  input wire logic pinHold,
  input wire logic oscEnable,
  input wire logic flashStart,
  output logic extResetn = 1'b0,
  output logic oscRunning = 1'b0,
  output logic oscTick = 1'b0,
  output logic flashInitDone = 1'b0
);
  // Ticks every other cycle, only while running; flash waits on the oscillator
  always @(posedge clk) begin
    extResetn <= !pinHold;
    oscRunning <= oscEnable;
    oscTick <= oscRunning && !oscTick;
    flashInitDone <= flashStart && oscRunning;
  end
endmodule : reset_source_model

// >>> tb/reset_wakeup_watchdog_test.sv
// Bench for the reset sequencer: reset paths, wake-up delay and watchdog.
// Assumes the far-side source model and a 50 MHz clock.
`timescale 1ns/1ns
module reset_wakeup_watchdog_test;
  import reset_wakeup_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic pinHold = 1'b1;
  logic oscEnable = 1'b0;
  logic flashStart = 1'b0;
  logic powerDownExit = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] writeData = 32'h00000000;
  logic writeStrobe = 1'b0;
  logic readStrobe = 1'b0;
  logic extResetn, oscRunning, oscTick, flashInitDone, chipResetn, coreRun, irq;
  logic [31:0] readData, fetchAddress, rdVal, tmo;
  logic [7:0] badKey;
  int bad_count = 0;
  int compares = 0;
  int cyc, expCyc;
  always #10 clk = ~clk;
  reset_source_model far (.clk(clk), .pinHold(pinHold), .oscEnable(oscEnable),
    .flashStart(flashStart), .extResetn(extResetn), .oscRunning(oscRunning),
    .oscTick(oscTick), .flashInitDone(flashInitDone));
  reset_wakeup_watchdog #(.WAKE_COUNT(16)) dut (.clk(clk), .resetn(resetn),
    .extResetn(extResetn), .oscRunning(oscRunning), .oscTick(oscTick),
    .flashInitDone(flashInitDone), .powerDownExit(powerDownExit), .addr(addr),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .readData(readData), .chipResetn(chipResetn), .coreRun(coreRun),
    .fetchAddress(fetchAddress), .irq(irq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clk);
    writeStrobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    readStrobe <= 1'b1;
    @(posedge clk);
    readStrobe <= 1'b0;
    @(negedge clk);
    d = readData;
  endtask : rd
  task automatic wait_run(input logic want, input int lim);
    cyc = 0;
    while (chipResetn !== want) begin
      @(posedge clk);
      #1;
      cyc++;
      if (cyc > lim) begin
        bad_count++;
        $display("Error at %0t: wait ran out", $time);
        test_done();
      end
    end
  endtask : wait_run
  initial begin
    rdVal = $urandom(32'hf7ea);
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    pinHold <= 1'b0;
    oscEnable <= 1'b1;
    repeat (80) @(posedge clk);
    #1 check(chipResetn, 0);
    @(posedge clk);
    flashStart <= 1'b1;
    wait_run(1'b1, 200);
    check(fetchAddress, RESET_VECTOR);
    rd(ADDR_STATUS, rdVal);
    check(rdVal, 0);
    rd(4'hf, rdVal);
    check(rdVal, 0);
    @(posedge clk);
    pinHold <= 1'b1;
    repeat (2) @(posedge clk);
    pinHold <= 1'b0;
    repeat (20) @(posedge clk);
    #1 check(chipResetn, 1);
    // Timeouts below the minimum are raised to it
    wr(ADDR_TIMEOUT, $urandom & 32'h000000ff);
    rd(ADDR_TIMEOUT, rdVal);
    check(rdVal, WDT_MIN_TIMEOUT);
    badKey = FEED_KEY1 ^ (8'($urandom) | 8'h01);
    // Wrong key, then a correct first key broken by another write
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_IRQ_CLEAR, 32'h2);
      wr(ADDR_MODE, 32'h1);
      wr(ADDR_MODE, 32'h0);
      rd(ADDR_MODE, rdVal);
      check(rdVal[MODE_ENABLE_BIT], 1);
      wr(ADDR_FEED, (i == 0) ? {24'h0, badKey} : {24'h0, FEED_KEY1});
      if (i == 1) wr(ADDR_IRQ_ENABLE, 32'h2);
      rd(ADDR_STATUS, rdVal);
      check(rdVal[STATUS_FEEDERR_BIT], 1);
      rd(ADDR_MODE, rdVal);
      check(rdVal[MODE_ENABLE_BIT], 0);
      check(irq, i[0]);
    end
    wr(ADDR_IRQ_CLEAR, 32'h2);
    repeat (2) @(posedge clk);
    #1 check(irq, 0);
    tmo = WDT_MIN_TIMEOUT + ($urandom & 32'h3f);
    expCyc = int'(tmo) * WDT_PRESCALE;
    wr(ADDR_TIMEOUT, tmo);
    rd(ADDR_TIMEOUT, rdVal);
    check(rdVal, tmo);
    wr(ADDR_MODE, 32'h3);
    for (int i = 0; i < 2; i++) begin
      repeat (600 * i) @(posedge clk);
      wr(ADDR_FEED, {24'h0, FEED_KEY1});
      wr(ADDR_FEED, {24'h0, FEED_KEY2});
    end
    wait_run(1'b0, 1400);
    check(cyc + 8 >= expCyc && cyc <= expCyc + 8, 1);
    wait_run(1'b1, 200);
    rd(ADDR_STATUS, rdVal);
    check(rdVal[STATUS_WDRESET_BIT], 1);
    @(posedge clk);
    powerDownExit <= 1'b1;
    @(posedge clk);
    powerDownExit <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check(coreRun, 0);
    wait_run(1'b1, 200);
    @(posedge clk);
    pinHold <= 1'b1;
    repeat (20) @(posedge clk);
    #1 check(chipResetn, 0);
    @(posedge clk);
    pinHold <= 1'b0;
    wait_run(1'b1, 200);
    test_done();
  end
endmodule : reset_wakeup_watchdog_test
